/* otcc_pkg.sv */
package otcc_pkg;

    localparam int CLK_PERIOD_NS = 5;
    // Settling allowance for one triggered output change
    localparam int OUT_CHANGE_NS = 50;
    localparam int OUT_CHANGE_CYC_I = (OUT_CHANGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] OUT_CHANGE_CYC = OUT_CHANGE_CYC_I[3:0];

    localparam logic [15:0] VOLT_RST = 16'h0000;
    localparam logic [15:0] CURR_RST = 16'h0100;
    localparam logic [15:0] OVP_RST = 16'hffff;
    localparam logic [15:0] PDLY_RST = 16'h0014;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] OPC_REPLY = 8'h01;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [15:0] STEP_ONE = 16'h0001;

    typedef enum logic [4:0] {
        OTCC_NOP, OTCC_SEQ, OTCC_SET_VOLT, OTCC_SET_CURR, OTCC_SET_VTRIG,
        OTCC_SET_CTRIG, OTCC_OUT_ON, OTCC_OUT_OFF, OTCC_OCP_ON, OTCC_OCP_OFF,
        OTCC_SET_OVP, OTCC_SET_PDLY, OTCC_PROT_CLR, OTCC_ABORT, OTCC_RESET,
        OTCC_RECALL, OTCC_INIT, OTCC_CONT_ON, OTCC_CONT_OFF, OTCC_TRIG,
        OTCC_WAI, OTCC_OPC, OTCC_OPC_Q, OTCC_CLS, OTCC_SET_SRE, OTCC_SET_ESE
    } otcc_cmd_e;

    typedef enum logic [1:0] {
        OTCC_IDLE, OTCC_INITIATED, OTCC_OUT_CHANGE
    } otcc_trig_e;

endpackage

/* otcc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module otcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* otcc_ctrl.sv */
// Function
// - Sequential commands finish first; trigger commands run in parallel.
// - Wait command stalls later commands until all pending operations complete.
// - Completion query queues value 1 once nothing is pending.
// - Completion command sets status bit when done, without stalling commands.
// - Completion is false while the trigger system is not idle.
// - Device clear flushes buffers and readies for a fresh command.
// - Device clear leaves status, errors and configuration untouched.
// - On serial link a break acts as device clear.
// - Power-on: output disabled, voltage zero.
// - Power-on performs reset, status clear, preset, zero enable masks.
// - Current above limit lowers output voltage to hold the limit.
// - Enabled overcurrent protection turns output off at current limit.
// - Voltage above overvoltage limit turns output off.
// - Separate transient and acquisition trigger systems exist; only the transient one is modelled here.
// - Unprogrammed triggered level follows the immediate level.
// - Programmed triggered level stays fixed afterwards.
// - Trigger system powers up idle.
// - Idle trigger system ignores triggers.
// - Abort, reset or recall force trigger system idle.
// - Initiate moves idle to initiated, accepting triggers.
// - Without continuous mode, return to idle after each action.
// - Continuous mode stays initiated across triggers.
// - Trigger enters output change applying triggered levels, then leaves.
`timescale 1ns/10ps
`default_nettype none
module otcc_ctrl
    import otcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_op,
    input wire logic [15:0] cmd_arg,
    output logic cmd_ready,
    input wire logic resp_taken,
    output logic resp_valid,
    output logic [7:0] resp_data,
    input wire logic dev_clear_pin,
    input wire logic serial_break_pin,
    input wire logic serial_mode,
    input wire logic [15:0] meas_volt,
    input wire logic [15:0] meas_curr,
    output logic out_enable,
    output logic [15:0] volt_drive,
    output logic [15:0] curr_limit,
    output logic cc_mode,
    output logic ocp_tripped,
    output logic ovp_tripped,
    output logic opc_bit,
    output logic [7:0] sre_mask,
    output logic [7:0] ese_mask,
    output logic [1:0] trig_state,
    output logic buf_flush
);
    typedef struct packed {
        otcc_trig_e trig;
        logic [3:0] chg_cnt;
        logic cont;
        logic [15:0] volt_set;
        logic [15:0] curr_set;
        logic [15:0] vtrig;
        logic [15:0] ctrig;
        logic vtrig_prog;
        logic ctrig_prog;
        logic [15:0] ovp_lim;
        logic [15:0] pdly;
        logic [15:0] pcnt;
        logic ocp_en;
        logic out_en;
        logic [15:0] drive;
        logic cc;
        logic ocp_trip;
        logic ovp_trip;
        logic wai;
        logic opcq;
        logic opc_arm;
        logic opc_bit;
        logic resp_valid;
        logic ready;
        logic flush;
        logic [7:0] sre;
        logic [7:0] ese;
        logic prev_clr;
        logic prev_brk;
    } otcc_st_s;

    otcc_st_s st_q;
    otcc_st_s st_d;
    logic [1:0] pins_s;
    logic clr_s;
    logic brk_s;
    logic dc_ev;
    logic acc;
    logic pending;
    logic [15:0] vtrig_eff;
    logic [15:0] ctrig_eff;

    // External pins are asynchronous to the core
    otcc_sync #(.WIDTH(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({serial_break_pin, dev_clear_pin}),
        .sync_out(pins_s)
    );
    assign clr_s = pins_s[0];
    assign brk_s = pins_s[1];
    assign dc_ev = (clr_s & ~st_q.prev_clr) | (serial_mode & brk_s & ~st_q.prev_brk);
    assign acc = cmd_valid & st_q.ready & ~dc_ev;
    assign pending = (st_q.trig != OTCC_IDLE);
    assign vtrig_eff = st_q.vtrig_prog ? st_q.vtrig : st_q.volt_set;
    assign ctrig_eff = st_q.ctrig_prog ? st_q.ctrig : st_q.curr_set;

    always_comb begin
        st_d = st_q;
        st_d.prev_clr = clr_s;
        st_d.prev_brk = brk_s;
        st_d.flush = 1'b0;
        if (resp_taken) begin
            st_d.resp_valid = 1'b0;
        end
        // Trigger state machine; trigger commands never stall the queue
        case (st_q.trig)
            OTCC_IDLE: begin
                if (acc && cmd_op == OTCC_INIT) begin
                    st_d.trig = OTCC_INITIATED;
                end
            end
            OTCC_INITIATED: begin
                if (acc && cmd_op == OTCC_TRIG) begin
                    st_d.trig = OTCC_OUT_CHANGE;
                    st_d.chg_cnt = OUT_CHANGE_CYC;
                    st_d.volt_set = vtrig_eff;
                    st_d.curr_set = ctrig_eff;
                end
            end
            OTCC_OUT_CHANGE: begin
                st_d.chg_cnt = st_q.chg_cnt - CNT_ONE;
                if (st_q.chg_cnt == CNT_ONE) begin
                    st_d.trig = st_q.cont ? OTCC_INITIATED : OTCC_IDLE;
                end
            end
            default: begin
                st_d.trig = OTCC_IDLE;
            end
        endcase
        if (acc) begin
            // Sequential commands complete in this cycle
            case (cmd_op)
                OTCC_SET_VOLT: st_d.volt_set = cmd_arg;
                OTCC_SET_CURR: st_d.curr_set = cmd_arg;
                OTCC_SET_VTRIG: begin
                    st_d.vtrig = cmd_arg;
                    st_d.vtrig_prog = 1'b1;
                end
                OTCC_SET_CTRIG: begin
                    st_d.ctrig = cmd_arg;
                    st_d.ctrig_prog = 1'b1;
                end
                OTCC_OUT_ON: st_d.out_en = 1'b1;
                OTCC_OUT_OFF: st_d.out_en = 1'b0;
                OTCC_OCP_ON: st_d.ocp_en = 1'b1;
                OTCC_OCP_OFF: st_d.ocp_en = 1'b0;
                OTCC_SET_OVP: st_d.ovp_lim = cmd_arg;
                OTCC_SET_PDLY: st_d.pdly = cmd_arg;
                OTCC_PROT_CLR: begin
                    st_d.ocp_trip = 1'b0;
                    st_d.ovp_trip = 1'b0;
                end
                OTCC_ABORT, OTCC_RECALL: st_d.trig = OTCC_IDLE;
                OTCC_RESET: begin
                    st_d.trig = OTCC_IDLE;
                    st_d.cont = 1'b0;
                    st_d.out_en = 1'b0;
                    st_d.volt_set = VOLT_RST;
                    st_d.curr_set = CURR_RST;
                    st_d.vtrig_prog = 1'b0;
                    st_d.ctrig_prog = 1'b0;
                    st_d.ovp_lim = OVP_RST;
                    st_d.pdly = PDLY_RST;
                    st_d.ocp_en = 1'b0;
                end
                OTCC_CONT_ON: begin
                    st_d.cont = 1'b1;
                    if (st_q.trig == OTCC_IDLE) begin
                        st_d.trig = OTCC_INITIATED;
                    end
                end
                OTCC_CONT_OFF: st_d.cont = 1'b0;
                OTCC_WAI: st_d.wai = 1'b1;
                OTCC_OPC: st_d.opc_arm = 1'b1;
                OTCC_OPC_Q: st_d.opcq = 1'b1;
                OTCC_CLS: begin
                    st_d.opc_bit = 1'b0;
                    st_d.opc_arm = 1'b0;
                end
                OTCC_SET_SRE: st_d.sre = cmd_arg[7:0];
                OTCC_SET_ESE: st_d.ese = cmd_arg[7:0];
                default: begin
                end
            endcase
        end
        // Completion tracking: only an idle trigger system counts as done
        if (!pending) begin
            st_d.wai = 1'b0;
            if (st_q.opc_arm) begin
                st_d.opc_arm = 1'b0;
                st_d.opc_bit = 1'b1;
            end
            if (st_q.opcq && !st_q.resp_valid) begin
                st_d.opcq = 1'b0;
                st_d.resp_valid = 1'b1;
            end
        end
        // Device clear drops only the queues and any stalled wait
        if (dc_ev) begin
            st_d.wai = 1'b0;
            st_d.opcq = 1'b0;
            st_d.resp_valid = 1'b0;
            st_d.flush = 1'b1;
        end
        st_d.ready = ~(st_d.wai | st_d.opcq);
        // Holding at the exact limit keeps cc steady for the trip delay
        st_d.cc = st_q.out_en && (meas_curr >= st_q.curr_set);
        if (!st_q.out_en) begin
            st_d.drive = VOLT_RST;
        end else if (meas_curr > st_q.curr_set) begin
            if (st_q.drive != VOLT_RST) begin
                st_d.drive = st_q.drive - STEP_ONE;
            end
        end else if (st_q.drive < st_q.volt_set) begin
            if (!st_d.cc) begin
                st_d.drive = st_q.drive + STEP_ONE;
            end
        end else begin
            st_d.drive = st_q.volt_set;
        end
        // Overcurrent waits out the protection delay before tripping
        if (st_q.ocp_en && st_q.cc) begin
            if (st_q.pcnt >= st_q.pdly) begin
                st_d.out_en = 1'b0;
                st_d.ocp_trip = 1'b1;
            end else begin
                st_d.pcnt = st_q.pcnt + STEP_ONE;
            end
        end else begin
            st_d.pcnt = '0;
        end
        if (st_q.out_en && (meas_volt > st_q.ovp_lim)) begin
            st_d.out_en = 1'b0;
            st_d.ovp_trip = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.trig <= OTCC_IDLE;
            st_q.volt_set <= VOLT_RST;
            st_q.curr_set <= CURR_RST;
            st_q.ovp_lim <= OVP_RST;
            st_q.pdly <= PDLY_RST;
            st_q.drive <= VOLT_RST;
            st_q.sre <= MASK_RST;
            st_q.ese <= MASK_RST;
            st_q.ready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign cmd_ready = st_q.ready;
    assign resp_valid = st_q.resp_valid;
    assign resp_data = OPC_REPLY;
    assign out_enable = st_q.out_en;
    assign volt_drive = st_q.drive;
    assign curr_limit = st_q.curr_set;
    assign cc_mode = st_q.cc;
    assign ocp_tripped = st_q.ocp_trip;
    assign ovp_tripped = st_q.ovp_trip;
    assign opc_bit = st_q.opc_bit;
    assign sre_mask = st_q.sre;
    assign ese_mask = st_q.ese;
    assign trig_state = st_q.trig;
    assign buf_flush = st_q.flush;

    property p_opc_idle;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(opc_bit) |-> $past(trig_state) == OTCC_IDLE;
    endproperty
    a_opc_idle: assert property (p_opc_idle) else $error("opc bit set while busy");

    property p_opcq_reply;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(resp_valid) |-> resp_data == 8'h01 && $past(trig_state) == OTCC_IDLE;
    endproperty
    a_opcq_reply: assert property (p_opcq_reply) else $error("bad completion reply");

    property p_idle_ignore;
        @(posedge core_clk) disable iff (!rst_n)
        (acc && cmd_op == OTCC_TRIG && trig_state == OTCC_IDLE) |=> trig_state == OTCC_IDLE;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("idle took trigger");

    property p_abort_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (acc && (cmd_op == OTCC_ABORT || cmd_op == OTCC_RESET || cmd_op == OTCC_RECALL))
            |=> trig_state == OTCC_IDLE;
    endproperty
    a_abort_idle: assert property (p_abort_idle) else $error("abort not idle");

    property p_init;
        @(posedge core_clk) disable iff (!rst_n)
        (acc && cmd_op == OTCC_INIT && trig_state == OTCC_IDLE) |=> trig_state == OTCC_INITIATED;
    endproperty
    a_init: assert property (p_init) else $error("initiate failed");

    property p_change_len;
        @(posedge core_clk) disable iff (!rst_n)
        (acc && cmd_op == OTCC_TRIG && trig_state == OTCC_INITIATED)
            |=> (trig_state == OTCC_OUT_CHANGE)[*8] ##1 (trig_state == OTCC_OUT_CHANGE)[*2]
            ##1 trig_state != OTCC_OUT_CHANGE;
    endproperty
    a_change_len: assert property (p_change_len) else $error("output change length");

    property p_ovp;
        @(posedge core_clk) disable iff (!rst_n)
        (out_enable && meas_volt > st_q.ovp_lim) |=> !out_enable && ovp_tripped;
    endproperty
    a_ovp: assert property (p_ovp) else $error("overvoltage not tripped");

    property p_devclr;
        @(posedge core_clk) disable iff (!rst_n)
        dc_ev |=> !resp_valid && cmd_ready && buf_flush && $stable(opc_bit);
    endproperty
    a_devclr: assert property (p_devclr) else $error("device clear wrong");

    property p_wai;
        @(posedge core_clk) disable iff (!rst_n)
        (acc && cmd_op == OTCC_WAI && trig_state != OTCC_IDLE && !dc_ev) |=> !cmd_ready;
    endproperty
    a_wai: assert property (p_wai) else $error("wait did not stall");

    property p_cont;
        @(posedge core_clk) disable iff (!rst_n)
        (trig_state == OTCC_OUT_CHANGE && st_q.chg_cnt == 4'h1 && st_q.cont)
            |=> trig_state == OTCC_INITIATED;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous lost");
endmodule
`default_nettype wire

/* otcc_load.sv */
`timescale 1ns/10ps
`default_nettype none
module otcc_load (
    input wire logic out_enable,
    input wire logic [15:0] volt_drive,
    input wire logic [3:0] load_gain,
    output logic [15:0] meas_volt,
    output logic [15:0] meas_curr
);
    // Resistive load; a heavier gain pushes the current past the limit
    always_comb begin
        meas_volt = out_enable ? volt_drive : 16'h0000;
        meas_curr = meas_volt * {12'h000, load_gain};
    end
endmodule
`default_nettype wire

/* otcc_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module otcc_ctrl_bench
    import otcc_pkg::*;
;
    logic core_clk, rst_n, cmd_valid, resp_taken, dev_clear_pin, serial_break_pin, serial_mode;
    logic [4:0] cmd_op;
    logic [15:0] cmd_arg, meas_volt, meas_curr, volt_drive, curr_limit;
    logic cmd_ready, resp_valid, out_enable, cc_mode, ocp_tripped, ovp_tripped, opc_bit;
    logic buf_flush;
    logic [7:0] resp_data, sre_mask, ese_mask;
    logic [1:0] trig_state;
    logic [3:0] load_gain;
    int err_count = 0;
    int n_compared = 0;

    otcc_ctrl otcc_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .resp_taken(resp_taken),
        .resp_valid(resp_valid), .resp_data(resp_data), .dev_clear_pin(dev_clear_pin),
        .serial_break_pin(serial_break_pin), .serial_mode(serial_mode), .meas_volt(meas_volt),
        .meas_curr(meas_curr), .out_enable(out_enable), .volt_drive(volt_drive),
        .curr_limit(curr_limit), .cc_mode(cc_mode), .ocp_tripped(ocp_tripped),
        .ovp_tripped(ovp_tripped), .opc_bit(opc_bit), .sre_mask(sre_mask),
        .ese_mask(ese_mask), .trig_state(trig_state), .buf_flush(buf_flush));
    otcc_load otcc_load_i (.out_enable(out_enable), .volt_drive(volt_drive),
        .load_gain(load_gain), .meas_volt(meas_volt), .meas_curr(meas_curr));

    always #2.5 core_clk = ~core_clk;

    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Held until an edge that sees cmd_ready high takes it
    task automatic send(input otcc_cmd_e op, input logic [15:0] arg);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_arg = arg;
        while (cmd_ready !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        `CHK(cmd_ready, 1'b1)
        step(1);
        // One idle edge so back-to-back calls never retoggle valid at once
        cmd_valid = 1'b0;
        step(1);
    endtask

    function automatic logic flag(input int sel);
        case (sel)
            0: return buf_flush;
            1: return resp_valid;
            2: return cc_mode;
            3: return ocp_tripped;
            default: return ovp_tripped;
        endcase
    endfunction

    task automatic wait_flag(input int sel, input int lim);
        int n;
        n = 0;
        while (flag(sel) !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
        `CHK(flag(sel), 1'b1)
    endtask

    initial begin
        #200us;
        err_count++;
        results();
    end

    initial begin
        otcc_cmd_e idle_ops[3] = '{OTCC_ABORT, OTCC_RECALL, OTCC_RESET};
        logic seen;
        {core_clk, rst_n, cmd_valid, resp_taken, dev_clear_pin, serial_break_pin} = '0;
        serial_mode = 1'b0;
        cmd_op = 5'h00;
        cmd_arg = 16'h0000;
        load_gain = 4'h1;
        step(12);
        rst_n = 1'b1;
        step(1);
        `CHK(out_enable, 1'b0)
        `CHK(volt_drive, 16'h0000)
        `CHK({sre_mask, ese_mask, opc_bit}, 17'h00000)
        `CHK(trig_state, 2'h0)
        `CHK({resp_valid, cmd_ready, curr_limit}, 18'h10100)
        send(OTCC_TRIG, 16'h0000);
        step(2);
        `CHK(trig_state, 2'h0)
        send(OTCC_SET_VOLT, 16'h0020);
        send(OTCC_OUT_ON, 16'h0000);
        step(60);
        send(OTCC_INIT, 16'h0000);
        `CHK(trig_state, 2'h1)
        send(OTCC_OPC, 16'h0000);
        step(3);
        `CHK(opc_bit, 1'b0)
        send(OTCC_TRIG, 16'h0000);
        `CHK(trig_state, 2'h2)
        step(8);
        `CHK(trig_state, 2'h2)
        step(1);
        `CHK(trig_state, 2'h0)
        step(3);
        `CHK(opc_bit, 1'b1)
        step(60);
        `CHK(volt_drive, 16'h0020)
        send(OTCC_SET_VTRIG, 16'h0030);
        send(OTCC_SET_VOLT, 16'h0008);
        step(40);
        send(OTCC_INIT, 16'h0000);
        send(OTCC_TRIG, 16'h0000);
        step(60);
        `CHK(volt_drive, 16'h0030)
        send(OTCC_INIT, 16'h0000);
        send(OTCC_TRIG, 16'h0000);
        send(OTCC_OPC_Q, 16'h0000);
        `CHK({trig_state, resp_valid}, 3'h4)
        wait_flag(1, 30);
        `CHK(trig_state, 2'h0)
        `CHK(resp_data, 8'h01)
        resp_taken = 1'b1;
        step(1);
        resp_taken = 1'b0;
        step(1);
        `CHK(resp_valid, 1'b0)
        send(OTCC_INIT, 16'h0000);
        send(OTCC_TRIG, 16'h0000);
        send(OTCC_WAI, 16'h0000);
        send(OTCC_SET_SRE, 16'h005a);
        `CHK(trig_state, 2'h0)
        `CHK(sre_mask, 8'h5a)
        send(OTCC_SET_ESE, 16'h00a5);
        // Reply left unread so the clear has something to flush
        send(OTCC_OPC_Q, 16'h0000);
        wait_flag(1, 10);
        dev_clear_pin = 1'b1;
        wait_flag(0, 10);
        dev_clear_pin = 1'b0;
        `CHK({resp_valid, cmd_ready}, 2'h1)
        `CHK({sre_mask, ese_mask, opc_bit, out_enable}, 18'h16a97)
        `CHK(volt_drive, 16'h0030)
        seen = 1'b0;
        serial_break_pin = 1'b1;
        repeat (10) begin
            step(1);
            seen = seen | buf_flush;
        end
        `CHK(seen, 1'b0)
        serial_break_pin = 1'b0;
        step(4);
        serial_mode = 1'b1;
        serial_break_pin = 1'b1;
        wait_flag(0, 10);
        serial_break_pin = 1'b0;
        load_gain = 4'h4;
        send(OTCC_SET_CURR, 16'h0020);
        wait_flag(2, 100);
        step(100);
        `CHK(volt_drive < 16'h0030, 1'b1)
        `CHK({out_enable, ocp_tripped}, 2'h2)
        send(OTCC_SET_PDLY, 16'h0005);
        send(OTCC_OCP_ON, 16'h0000);
        wait_flag(3, 40);
        `CHK(out_enable, 1'b0)
        send(OTCC_PROT_CLR, 16'h0000);
        send(OTCC_OCP_OFF, 16'h0000);
        load_gain = 4'h1;
        send(OTCC_SET_CURR, 16'h0100);
        send(OTCC_SET_OVP, 16'h0020);
        send(OTCC_OUT_ON, 16'h0000);
        wait_flag(4, 100);
        `CHK(out_enable, 1'b0)
        send(OTCC_PROT_CLR, 16'h0000);
        send(OTCC_CLS, 16'h0000);
        `CHK(opc_bit, 1'b0)
        send(OTCC_CONT_ON, 16'h0000);
        `CHK(trig_state, 2'h1)
        repeat (2) begin
            send(OTCC_TRIG, 16'h0000);
            step(10);
            `CHK(trig_state, 2'h1)
        end
        send(OTCC_CONT_OFF, 16'h0000);
        // Reset last, since it also returns the settings to defaults
        foreach (idle_ops[i]) begin
            send(OTCC_INIT, 16'h0000);
            `CHK(trig_state, 2'h1)
            send(idle_ops[i], 16'h0000);
            `CHK(trig_state, 2'h0)
        end
        results();
    end
endmodule
`default_nettype wire
